// *** core/ckp_pin_ctl.sv ***
// module: card pin control and status register with its pin drivers
//
// Behaviour
// - sync flag reads 1 while a written setting is in transfer, then 0.
// - bit 18 reads the card reset pin level, 1 for high.
// - bit 17 reads the card power pin level, 1 for high.
// - bit 16 reads the card data pin level, 1 for high.
// - power pin equals power inversion bit XOR power enable bit.
// - writing data drive 0 pulls the data pin low, 1 releases it high.
// - reading the data drive bit returns the live data pin level.
// - sequences update the data drive bit; software leaves it alone then.
// - clock run 0 stops the card clock, 1 lets it run freely.
// - sequences change clock run; software leaves it alone then.
// - power enable write drives the power pin; read returns its level.
`timescale 1ns/1ps
`default_nettype none
module ckp_pin_ctl
    import ckp_pkg::*;
#(
    parameter int XFER_CYCLES = CKP_XFER_CYCLES,
    parameter int CLK_HALF_CYCLES = CKP_CLK_HALF_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [CKP_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // sequencer side
    input wire logic seq_active_i,
    input wire logic seq_data_drive_i,
    input wire logic seq_clock_run_i,
    input wire logic card_reset_drive_i,
    // card pins
    output logic card_reset_pin_o,
    output logic card_power_pin_o,
    output logic card_clk_o,
    input wire logic card_io_pin_i,
    output logic card_io_pin_o,
    output logic card_io_pin_oe_o
);

    localparam int HW = (CLK_HALF_CYCLES > 1) ? $clog2(CLK_HALF_CYCLES) : 1;

    ////////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    // the clock divider needs at least one cycle per half period
    if (CLK_HALF_CYCLES < 1) begin : g_bad_half
        $error("ckp_pin_ctl: CLK_HALF_CYCLES must be at least 1");
    end

    // the transfer needs at least one cycle
    if (XFER_CYCLES < 1) begin : g_bad_xfer
        $error("ckp_pin_ctl: XFER_CYCLES must be at least 1");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        ckp_pin_cfg_t shadow;
        logic load;
        logic data_drive;
        logic clock_run;
        logic seq_was;
        logic [HW-1:0] div_cnt;
        logic card_clk;
        logic reset_pin;
        logic power_pin;
        logic io_oe;
    } ckp_state_t;

    ckp_state_t st_reg;
    ckp_state_t st_next;

    // transfer port
    logic xfer_busy;
    logic xfer_done;
    ckp_pin_cfg_t xfer_cfg;

    // bus decode
    logic req;
    logic hit;
    logic wr_commit;

    // register view
    logic [31:0] rd_word;

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode

    // a request is answered one cycle after it appears
    assign req = wb_cyc_i & wb_stb_i;
    assign hit = (wb_adr_i[CKP_ADR_W-1:2] == CKP_PIN_CTL_OFFSET[CKP_ADR_W-1:2]);
    // the write lands on the edge at which ack is high
    assign wr_commit = req & wb_we_i & st_reg.ack & hit;

    ////////////////////////////////////////////////////////////////////////////////
    // read view

    // status bits, data drive and power enable show pin levels, sync flag the transfer, other control fields their current state, all other bits read 0
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_word[CKP_SYNC_BIT] = xfer_busy;
        rd_word[CKP_RESET_LEVEL_BIT] = st_reg.reset_pin;
        rd_word[CKP_POWER_LEVEL_BIT] = st_reg.power_pin;
        rd_word[CKP_DATA_LEVEL_BIT] = card_io_pin_i;
        rd_word[CKP_POWER_INVERT_BIT] = st_reg.shadow.power_polarity_invert;
        rd_word[CKP_DATA_DRIVE_BIT] = card_io_pin_i;
        rd_word[CKP_CLOCK_RUN_BIT] = st_reg.clock_run;
        rd_word[CKP_POWER_DRIVE_BIT] = st_reg.power_pin;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_next = st_reg;
        st_next.load = 1'b0;

        // single wait state handshake, ack drops the cycle after
        st_next.ack = req & ~st_reg.ack;
        if (req & ~st_reg.ack) begin
            st_next.rdat = hit ? rd_word : 32'h0000_0000;
        end

        // register write: only writable fields, by byte lane
        if (wr_commit & ~xfer_busy) begin
            st_next.load = 1'b1;
            if (wb_sel_i[CKP_POWER_INVERT_BIT / 8]) begin
                st_next.shadow.power_polarity_invert = wb_dat_i[CKP_POWER_INVERT_BIT];
            end
            if (wb_sel_i[CKP_POWER_DRIVE_BIT / 8]) begin
                st_next.shadow.power_pin_drive = wb_dat_i[CKP_POWER_DRIVE_BIT];
            end
            // sequence owned bits keep their value while one runs
            if (wb_sel_i[CKP_DATA_DRIVE_BIT / 8] & ~seq_active_i) begin
                st_next.shadow.data_pin_drive = wb_dat_i[CKP_DATA_DRIVE_BIT];
            end
            if (wb_sel_i[CKP_CLOCK_RUN_BIT / 8] & ~seq_active_i) begin
                st_next.shadow.card_clock_free_run = wb_dat_i[CKP_CLOCK_RUN_BIT];
            end
        end

        // sequencer takes the data and clock settings while active
        st_next.seq_was = seq_active_i;
        if (seq_active_i) begin
            st_next.data_drive = seq_data_drive_i;
            st_next.clock_run = seq_clock_run_i;
        end else if (st_reg.seq_was) begin
            // keep what the sequence left, and show it in the register
            st_next.shadow.data_pin_drive = st_reg.data_drive;
            st_next.shadow.card_clock_free_run = st_reg.clock_run;
        end else if (xfer_done) begin
            st_next.data_drive = xfer_cfg.data_pin_drive;
            st_next.clock_run = xfer_cfg.card_clock_free_run;
        end

        // power pin: inversion xor enable
        st_next.power_pin = xfer_cfg.power_polarity_invert
                          ^ xfer_cfg.power_pin_drive;

        // reset pin follows the reset drive from the sequencer side
        st_next.reset_pin = card_reset_drive_i;

        // data pin is open drain: pull low for 0, release for 1
        st_next.io_oe = ~st_reg.data_drive;

        // card clock divider, held low when stopped
        if (st_reg.clock_run) begin
            if (st_reg.div_cnt == HW'(CLK_HALF_CYCLES - 1)) begin
                st_next.div_cnt = '0;
                st_next.card_clk = ~st_reg.card_clk;
            end else begin
                st_next.div_cnt = st_reg.div_cnt + 1'b1;
            end
        end else begin
            st_next.div_cnt = '0;
            st_next.card_clk = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg.ack <= 1'b0;
            st_reg.rdat <= 32'h0000_0000;
            st_reg.shadow <= '{CKP_POWER_INVERT_RST, CKP_POWER_DRIVE_RST,
                               CKP_DATA_DRIVE_RST, CKP_CLOCK_RUN_RST};
            st_reg.load <= 1'b0;
            st_reg.data_drive <= CKP_DATA_DRIVE_RST;
            st_reg.clock_run <= CKP_CLOCK_RUN_RST;
            st_reg.seq_was <= 1'b0;
            st_reg.div_cnt <= '0;
            st_reg.card_clk <= 1'b0;
            st_reg.reset_pin <= 1'b0;
            st_reg.power_pin <= CKP_POWER_INVERT_RST ^ CKP_POWER_DRIVE_RST;
            st_reg.io_oe <= ~CKP_DATA_DRIVE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // transfer of the written setting into the pin logic

    ckp_sync_xfer #(
        .XFER_CYCLES(XFER_CYCLES)
    ) u_xfer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(st_reg.load),
        .data_i(st_reg.shadow),
        .busy_o(xfer_busy),
        .done_o(xfer_done),
        .data_o(xfer_cfg)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // outputs, all from flops except the constant data pin output

    assign wb_ack_o = st_reg.ack;
    assign wb_dat_o = st_reg.rdat;
    assign card_reset_pin_o = st_reg.reset_pin;
    assign card_power_pin_o = st_reg.power_pin;
    assign card_clk_o = st_reg.card_clk;
    assign card_io_pin_o = 1'b0; // only ever pulls low
    assign card_io_pin_oe_o = st_reg.io_oe;

endmodule // ckp_pin_ctl
`default_nettype wire

// *** core/ckp_pkg.sv ***
// package: offsets, field positions, reset values and timing of the pin control block
package ckp_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [7:0] CKP_PIN_CTL_OFFSET = 8'h24;
    localparam int CKP_ADR_W = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions inside card_pin_control_state
    localparam int CKP_SYNC_BIT = 30;
    localparam int CKP_RESET_LEVEL_BIT = 18;
    localparam int CKP_POWER_LEVEL_BIT = 17;
    localparam int CKP_DATA_LEVEL_BIT = 16;
    localparam int CKP_POWER_INVERT_BIT = 11;
    localparam int CKP_DATA_DRIVE_BIT = 9;
    localparam int CKP_CLOCK_RUN_BIT = 6;
    localparam int CKP_POWER_DRIVE_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values of the writable fields
    localparam logic CKP_POWER_INVERT_RST = 1'b0;
    localparam logic CKP_POWER_DRIVE_RST = 1'b0;
    localparam logic CKP_DATA_DRIVE_RST = 1'b1;
    localparam logic CKP_CLOCK_RUN_RST = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // timing, in cycles of the 100 MHz clock
    localparam int CKP_XFER_CYCLES = 3;
    localparam int CKP_CLK_HALF_CYCLES = 2;

    // settings carried from the register into the pin logic
    typedef struct packed {
        logic power_polarity_invert;
        logic power_pin_drive;
        logic data_pin_drive;
        logic card_clock_free_run;
    } ckp_pin_cfg_t;

endpackage

// *** core/ckp_sync_xfer.sv ***
// module: carries a written pin setting into the pin logic and reports it busy meanwhile
`timescale 1ns/1ps
`default_nettype none
module ckp_sync_xfer
    import ckp_pkg::*;
#(
    parameter int XFER_CYCLES = CKP_XFER_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire ckp_pin_cfg_t data_i,
    output logic busy_o,
    output logic done_o,
    output ckp_pin_cfg_t data_o
);

    localparam int CW = (XFER_CYCLES > 1) ? $clog2(XFER_CYCLES) : 1;

    // refuse a transfer that could not take even one cycle
    if (XFER_CYCLES < 1) begin : g_bad_cycles
        $error("ckp_sync_xfer: XFER_CYCLES must be at least 1");
    end

    typedef struct packed {
        logic busy;
        logic done;
        logic [CW-1:0] cnt;
        ckp_pin_cfg_t hold;
        ckp_pin_cfg_t out;
    } ckp_xfer_state_t;

    ckp_xfer_state_t st_reg;
    ckp_xfer_state_t st_next;

    // a load while busy is dropped: the setting in flight is finished first
    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        if (st_reg.busy) begin
            if (st_reg.cnt == '0) begin
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
                st_next.out = st_reg.hold;
            end else begin
                st_next.cnt = st_reg.cnt - 1'b1;
            end
        end else if (load_i) begin
            st_next.busy = 1'b1;
            st_next.cnt = CW'(XFER_CYCLES - 1);
            st_next.hold = data_i;
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg.busy <= 1'b0;
            st_reg.done <= 1'b0;
            st_reg.cnt <= '0;
            st_reg.hold <= '{CKP_POWER_INVERT_RST, CKP_POWER_DRIVE_RST,
                             CKP_DATA_DRIVE_RST, CKP_CLOCK_RUN_RST};
            st_reg.out <= '{CKP_POWER_INVERT_RST, CKP_POWER_DRIVE_RST,
                            CKP_DATA_DRIVE_RST, CKP_CLOCK_RUN_RST};
        end else begin
            st_reg <= st_next;
        end
    end

    assign busy_o = st_reg.busy;
    assign done_o = st_reg.done;
    assign data_o = st_reg.out;

endmodule // ckp_sync_xfer
`default_nettype wire

// *** testbench/ckp_card_model.sv ***
// card side of the data line: open drain with pull-up
`timescale 1ns/1ps
`default_nettype none
module ckp_card_model (
    input wire logic io_oe_i,
    input wire logic pull_low_i,
    output logic io_level_o
);
    // line is high unless the host or the card pulls it low
    assign io_level_o = !(io_oe_i || pull_low_i);
endmodule // ckp_card_model
`default_nettype wire

// *** testbench/ckp_pin_ctl_monitor.sv ***
// assertions on the ports of the pin control block
`timescale 1ns/1ps
`default_nettype none
module ckp_pin_ctl_monitor
    import ckp_pkg::*;
#(
    parameter int XFER_CYCLES = 3,
    parameter int CLK_HALF_CYCLES = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [CKP_ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic card_reset_drive_i,
    input wire logic card_reset_pin_o,
    input wire logic card_power_pin_o,
    input wire logic card_clk_o,
    input wire logic card_io_pin_i,
    input wire logic card_io_pin_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] hi_cnt;
    logic [7:0] since_wr;
    // length of clock high phase and cycles since a register write
    always_ff @(posedge clk_i) begin
        hi_cnt <= (rst_i || !card_clk_o) ? 8'h00 : hi_cnt + 8'h01;
        if (rst_i) since_wr <= 8'hff;
        else if (wb_ack_o && wb_we_i && wb_adr_i[7:2] == CKP_PIN_CTL_OFFSET[7:2]) since_wr <= 8'h00;
        else if (since_wr != 8'hff) since_wr <= since_wr + 8'h01;
    end
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_rd;
        wb_ack_o && wb_cyc_i && !wb_we_i;
    endsequence
    sequence s_rd_reg;
        s_rd ##0 wb_adr_i[7:2] == CKP_PIN_CTL_OFFSET[7:2];
    endsequence
    sequence s_rd_other;
        s_rd ##0 wb_adr_i[7:2] != CKP_PIN_CTL_OFFSET[7:2];
    endsequence
    chk_ack_answer: assert property (s_req |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    chk_status_pins: assert property (s_rd_reg |-> wb_dat_o[18:16] ==
        {$past(card_reset_pin_o), $past(card_power_pin_o), $past(card_io_pin_i)})
        else $error("status bits differ from pins");
    chk_live_bits: assert property (s_rd_reg |-> wb_dat_o[9] == $past(card_io_pin_i)
        && wb_dat_o[0] == $past(card_power_pin_o)) else $error("live bits differ");
    chk_reserved_zero: assert property (s_rd |-> (wb_dat_o & 32'hbff8_f5be) == 32'h0)
        else $error("reserved bits not zero");
    chk_unmapped_zero: assert property (s_rd_other |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_reset_follow: assert property (!$past(rst_i) |->
        card_reset_pin_o == $past(card_reset_drive_i)) else $error("reset pin lags");
    chk_io_low: assert property (card_io_pin_o == 1'b0)
        else $error("data pin output not low");
    chk_clk_half: assert property (card_clk_o |-> hi_cnt < CLK_HALF_CYCLES)
        else $error("card clock high too long");
    chk_power_time: assert property ($changed(card_power_pin_o) |->
        since_wr == XFER_CYCLES + 2) else $error("power pin moved off schedule");
endmodule // ckp_pin_ctl_monitor
bind ckp_pin_ctl ckp_pin_ctl_monitor #(
    .XFER_CYCLES(XFER_CYCLES),
    .CLK_HALF_CYCLES(CLK_HALF_CYCLES)
) u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .card_reset_drive_i(card_reset_drive_i), .card_reset_pin_o(card_reset_pin_o),
    .card_power_pin_o(card_power_pin_o), .card_clk_o(card_clk_o),
    .card_io_pin_i(card_io_pin_i), .card_io_pin_o(card_io_pin_o));
`default_nettype wire

// *** testbench/ckp_pin_ctl_tb.sv ***
// self-checking bench for the pin control block
`timescale 1ns/1ps
`default_nettype none
module ckp_pin_ctl_tb
    import ckp_pkg::*;
();
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack;
    logic seq_on = 0, seq_dat = 1, seq_clk = 0, rst_drv = 0, pull_low = 0;
    logic rpin, ppin, cclk, io_lvl, io_o, io_oe;
    logic [CKP_ADR_W-1:0] adr = 0;
    logic [31:0] dat = 0, rdat, q;
    int num_errors = 0, cmp_count = 0;
    always #5 clk_i = ~clk_i;
    ckp_pin_ctl #(.XFER_CYCLES(CKP_XFER_CYCLES), .CLK_HALF_CYCLES(CKP_CLK_HALF_CYCLES)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .seq_active_i(seq_on), .seq_data_drive_i(seq_dat), .seq_clock_run_i(seq_clk),
        .card_reset_drive_i(rst_drv), .card_reset_pin_o(rpin), .card_power_pin_o(ppin),
        .card_clk_o(cclk), .card_io_pin_i(io_lvl), .card_io_pin_o(io_o),
        .card_io_pin_oe_o(io_oe));
    ckp_card_model u_card (.io_oe_i(io_oe), .pull_low_i(pull_low), .io_level_o(io_lvl));
    ////////////////////////////////////////////////////////////////////////////////
    task end_of_test;
        if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one classic cycle, held until ack is sampled
    task bus(input logic w, input logic [CKP_ADR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        {cyc, stb} <= 2'b00;
        if (n >= 20) chk("ack", 32'h1, 32'h0);
    endtask
    task rd;
        bus(1'b0, CKP_PIN_CTL_OFFSET, 32'h0);
    endtask
    // write, see the busy flag, then poll until it clears
    task wr(input logic [31:0] d);
        int n;
        n = 0;
        bus(1'b1, CKP_PIN_CTL_OFFSET, d);
        rd;
        chk("sync_busy", 32'h1, 32'(q[30]));
        do begin
            rd;
            n++;
        end while (q[30] !== 1'b0 && n < 10);
        chk("sync_clear", 32'h0, 32'(q[30]));
        rd;
    endtask
    task count_hi(output int ups);
        ups = 0;
        repeat (16) begin
            @(posedge clk_i);
            ups += int'(cclk === 1'b1);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset_word;
        rd;
        chk("reset_word", 32'h0001_0200, q);
    endtask
    task t_power;
        logic [31:0] e;
        for (int i = 0; i < 4; i++) begin
            e = 32'h200 | (32'(i[1]) << 11) | 32'(i[0]);
            wr(e);
            chk("power_pin", 32'(i[1] ^ i[0]), 32'(ppin));
            // bit 0 reads back the power pin level, not the written enable
            e = 32'h0001_0200 | (32'(i[1]) << 11) | ((i[1] ^ i[0]) ? 32'h0002_0001 : 32'h0);
            chk("power_word", e, q);
        end
    endtask
    task t_data;
        wr(32'h0);
        chk("io_pulled", 32'h0, 32'(io_lvl));
        chk("data_bits", 32'h0, q & 32'h0001_0200);
        wr(32'h200);
        chk("io_released", 32'h1, 32'(io_lvl));
        pull_low <= 1'b1;
        rd;
        chk("data_live", 32'h0, q & 32'h0001_0200);
        pull_low <= 1'b0;
    endtask
    task t_clock;
        int ups;
        wr(32'h240);
        count_hi(ups);
        chk("clk_run", 32'd8, 32'(ups));
        wr(32'h200);
        count_hi(ups);
        chk("clk_stop", 32'd0, 32'(ups));
    endtask
    task t_reset_pin;
        rst_drv <= 1'b1;
        rd;
        chk("reset_level", 32'h1, 32'(q[18]));
        chk("reset_pin", 32'h1, 32'(rpin));
        rst_drv <= 1'b0;
    endtask
    // sequencer owns data drive and clock run; a write to them is ignored
    task t_seq;
        int ups;
        {seq_on, seq_dat, seq_clk} <= 3'b101;
        wr(32'h200);
        chk("seq_data", 32'h1, 32'(io_oe));
        count_hi(ups);
        chk("seq_clk", 32'd8, 32'(ups));
        seq_on <= 1'b0;
        wr(32'h200);
    endtask
    task t_unmapped;
        bus(1'b1, 8'h28, 32'hffff_ffff);
        bus(1'b0, 8'h28, 32'h0);
        chk("unmapped", 32'h0, q);
        wr(32'hffff_f7be);
        chk("reserved", 32'h0001_0200, q);
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_word;
        t_power;
        t_data;
        t_clock;
        t_reset_pin;
        t_seq;
        t_unmapped;
        end_of_test;
    end
    // watchdog
    initial begin
        #100000;
        num_errors++;
        end_of_test;
    end
endmodule // ckp_pin_ctl_tb
`default_nettype wire
